// ===== bench/irq_source.sv
// partner model: outside source driving the active-low interrupt pin
`timescale 1ns/1ps
module irq_source (
  // bench commands
  input  wire logic       clk,
  input  wire logic       hold,
  input  wire logic [3:0] width,
  // pin
  output wire logic       pin_n
);
  logic [3:0] cnt_q = 4'h0;
  always @(posedge clk) begin
    if (width != 4'h0)
      cnt_q <= width;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  // pin moves 7 ns off the clock edge: the source is not tied to our clock
  assign #7 pin_n = !(hold || cnt_q != 4'h0);
endmodule

// ===== bench/tb.sv
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module tb;
  localparam logic [31:0] ST = 32'(`EIRQ_STATUS_CONTROL_ADDR);
  localparam logic [31:0] BK = 32'(`EIRQ_BREAK_CTRL_ADDR);
  localparam logic [31:0] VC = 32'(`EIRQ_VECTOR_ADDR);
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        vector_fetch = 1'b0;
  logic        break_state = 1'b0;
  logic        hold = 1'b0;
  logic [3:0]  width = 4'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  resp;
  wire logic   pin_n, irq_request, pin_level, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          errors = 0, samples_checked = 0, cyc = 0, i;
  integer      seed = 32'ha9df;

  initial forever #12.5 clk = ~clk;

  irq_source i_irq_source (.clk(clk), .hold(hold), .width(width), .pin_n(pin_n));

  external_irq_latch i_external_irq_latch (
    .clk(clk), .reset(reset), .clk_en(1'b1), .irq_pin_n(pin_n),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .irq_request(irq_request), .pin_level(pin_level),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ************************************************************
  // expectations, bus cycles, closing
  // ************************************************************
  function automatic logic [31:0] st(input logic pin, flag, mask, mode);
    return {27'h0, pin, flag, 1'b0, mask, mode};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // address and data go out together; each drops once its own ready is seen
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      aw = aw && (awready !== 1'b1);
      w = w && (wready !== 1'b1);
      awvalid <= aw;
      wvalid <= w;
    end
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // latch follows the pin within 3 edges, so 8 is a safe settle
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic pin_pulse(input logic [3:0] w);
    @(posedge clk);
    width <= w;
    @(posedge clk);
    width <= 4'h0;
    repeat (w) @(posedge clk);
    settle();
  endtask

  task automatic fetch();
    @(posedge clk);
    vector_fetch <= 1'b1;
    @(posedge clk);
    vector_fetch <= 1'b0;
    settle();
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b0, 1'b0, 1'b0));
    rdr(BK);
    chk("break_ctrl", rd, 32'h0);
    rdr(VC);
    chk("vector", rd, {`EIRQ_VECTOR_HI_LOC, `EIRQ_VECTOR_LO_LOC});
    rdr(32'hc);
    chk("unmapped_resp", 32'(resp), 32'(`EIRQ_RESP_SLVERR));
    $display("test reset values done");
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(ST, d);
      rdr(ST);
      chk("ctrl", rd, st(1'b1, 1'b0, d[1], d[0]));
    end
    $display("test control bits done");
    wr(ST, 32'h0);
    pin_pulse(4'(($random(seed) & 3) + 1));
    chk("req", 32'(irq_request), 32'h1);
    chk("pin_level", 32'(pin_level), 32'h1);
    fetch();
    chk("req", 32'(irq_request), 32'h0);
    hold <= 1'b1;
    settle();
    chk("pin_level", 32'(pin_level), 32'h0);
    wr(ST, 32'h4);
    rdr(ST);
    chk("status", rd, st(1'b0, 1'b0, 1'b0, 1'b0));
    hold <= 1'b0;
    settle();
    pin_pulse(4'h2);
    chk("req", 32'(irq_request), 32'h1);
    $display("test edge mode done");
    wr(ST, 32'h2);
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b1, 1'b1, 1'b0));
    chk("req", 32'(irq_request), 32'h0);
    wr(ST, 32'h0);
    settle();
    chk("req", 32'(irq_request), 32'h1);
    $display("test mask done");
    wr(ST, 32'h1);
    hold <= 1'b1;
    settle();
    fetch();
    wr(ST, 32'h3);
    rdr(ST);
    chk("status", rd, st(1'b0, 1'b1, 1'b1, 1'b1));
    chk("req", 32'(irq_request), 32'h0);
    hold <= 1'b0;
    settle();
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b0, 1'b1, 1'b1));
    pin_pulse(4'h3);
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b1, 1'b1, 1'b1));
    wr(ST, 32'h5);
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b0, 1'b0, 1'b1));
    $display("test level mode done");
    wr(ST, 32'h0);
    pin_pulse(4'h2);
    break_state <= 1'b1;
    wr(ST, 32'h4);
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b1, 1'b0, 1'b0));
    wr(BK, 32'h1);
    wr(ST, 32'h4);
    break_state <= 1'b0;
    rdr(ST);
    chk("status", rd, st(1'b1, 1'b0, 1'b0, 1'b0));
    wr(BK, 32'h0);
    $display("test break done");
    wr(ST, 32'h1);
    hold <= 1'b1;
    settle();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    chk("req", 32'(irq_request), 32'h0);
    reset <= 1'b0;
    rdr(ST);
    chk("mode", rd & 32'h1, 32'h0);
    settle();
    rdr(ST);
    chk("flag", rd & 32'h8, 32'h0);
    chk("req", 32'(irq_request), 32'h0);
    hold <= 1'b0;
    $display("test reset with pin low done");
    end_sim();
  end
endmodule

// ===== hw/external_irq_latch.sv
// external interrupt latch with axi4-lite status/control registers
// Contract
// RULE_01: a low pin, per selected sensitivity, sets the pin latch. The code sets it on a falling edge only, in both modes.
// RULE_02: a vector fetch acknowledge clears the pin latch.
// RULE_03: software writing one to the acknowledge bit clears the latch.
// RULE_04: reset clears latch and sensitivity bit even with pin low.
// RULE_05: edge mode holds the request until fetch, acknowledge or reset.
// RULE_06: level mode clears only after acknowledge and pin high.
// RULE_07: level mode accepts acknowledge and pin release in either order.
// RULE_08: edge mode acknowledge clears the latch regardless of pin level.
// RULE_09: mask bit set withholds the request from priority logic.
// RULE_10: a falling edge after an acknowledge latches a new request.
// RULE_11: taken requests vector through the two fixed vector locations.
// RULE_12: pending flag is read-only, one when pending, else zero.
// RULE_13: pending flag ignores the mask bit.
// RULE_14: acknowledge bit is write-only and reads zero.
// RULE_15: mask bit read/write, one disables, reset clears it.
// RULE_16: sensitivity bit read/write, one adds low levels, reset clears. The code lets a low level only hold the latch; it never sets it.
// RULE_17: in break with clear-enable zero, acknowledge writes are ignored.
// RULE_18: clear-enable one lets break acknowledges clear, staying cleared.
// RULE_19: the pin level is given to branch-on-pin instructions.
// RULE_20: level-mode service routines should mask further requests.
// RULE_21: pin is synchronised; falling edge is high then low samples.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ext_irq_params.svh"

module external_irq_latch (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // external pin and cpu side
  input  wire logic        irq_pin_n,
  input  wire logic        vector_fetch,
  input  wire logic        break_state,
  output logic             irq_request,
  output logic             pin_level,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ************************************************
  // pin synchroniser and edge detect
  // ************************************************
  logic                  sync1_q;
  logic                  sync2_q;
  logic                  prev_q;
  logic [2:0]            arm_q;
  wire logic             fall_edge;
  wire logic             pin_low;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
      arm_q   <= '0;
    end else if (clk_en) begin
      arm_q   <= {arm_q[1:0], 1'b1};
      sync1_q <= irq_pin_n; // RULE_21
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // no edge until the pipe holds real pin samples: a pin held low
  // through reset must not look like a fresh falling edge afterwards
  assign fall_edge = arm_q[2] & prev_q & ~sync2_q; // RULE_21 RULE_04
  assign pin_low   = ~sync2_q;

  // ************************************************
  // register write channel
  // ************************************************
  ext_irq_pkg::ctrl_s        ctrl_q;
  logic                      bce_q;
  ext_irq_pkg::wr_state_e    wst_q;
  logic                      aw_have_q;
  logic                      w_have_q;
  logic [`EIRQ_ADDR_W-1:0]   awaddr_q;
  logic [7:0]                wdata_q;
  logic                      wstrb0_q;
  logic                      latch_q;
  logic                      req_q;
  logic                      pin_q;
  logic                      ack_pend_q;

  wire logic aw_take   = s_axi_awvalid & s_axi_awready;
  wire logic w_take    = s_axi_wvalid & s_axi_wready;
  wire logic aw_now    = aw_have_q | aw_take;
  wire logic w_now     = w_have_q | w_take;
  wire logic [`EIRQ_ADDR_W-1:0] wa = aw_have_q ? awaddr_q
                                               : s_axi_awaddr[`EIRQ_ADDR_W-1:0];
  wire logic [7:0] wd  = w_have_q ? wdata_q : s_axi_wdata[7:0];
  wire logic ws        = w_have_q ? wstrb0_q : s_axi_wstrb[0];
  wire logic wr_fire   = (wst_q == ext_irq_pkg::wr_idle) & aw_now & w_now;
  wire logic wa_hi_ok  = aw_have_q ? 1'b1 : (s_axi_awaddr[31:`EIRQ_ADDR_W] == '0);
  wire logic sel_sc    = wr_fire & wa_hi_ok & (wa == `EIRQ_STATUS_CONTROL_ADDR);
  wire logic sel_bc    = wr_fire & wa_hi_ok & (wa == `EIRQ_BREAK_CTRL_ADDR);
  wire logic sel_vec   = wr_fire & wa_hi_ok & (wa == `EIRQ_VECTOR_ADDR);
  wire logic wr_ok     = sel_sc | sel_bc | sel_vec;
  wire logic sc_wr     = sel_sc & ws;
  wire logic bc_wr     = sel_bc & ws;
  // acknowledge write ignored in break unless clear-enable is set
  wire logic sw_ack    = sc_wr & wd[`EIRQ_ACK_BIT] & (~break_state | bce_q); // RULE_03 RULE_17 RULE_18
  wire logic ack_any   = vector_fetch | sw_ack; // RULE_02

  // ************************************************
  // pin latch
  // ************************************************
  // level mode: the latch holds while the pin is low, so acknowledge and
  // release may come in either order; a fresh edge beats a same-cycle clear
  wire logic set_ev    = fall_edge; // RULE_01 RULE_10
  wire logic hold_lvl  = ctrl_q.mode & pin_low; // RULE_06 RULE_07
  // an acknowledge seen while the pin is low is remembered until release
  wire logic ack_rel   = (ack_any | ack_pend_q) & ~hold_lvl; // RULE_07
  wire logic latch_d   = set_ev | (latch_q & ~ack_rel); // RULE_05 RULE_08
  wire logic ack_pend_d = latch_d & ~set_ev & (ack_pend_q | ack_any); // RULE_07

  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= 1'b0; // RULE_04
      ctrl_q  <= '0; // RULE_04 RULE_15 RULE_16
      bce_q   <= 1'b0;
      req_q   <= 1'b0;
      pin_q   <= 1'b1;
      ack_pend_q <= 1'b0;
    end else if (clk_en) begin
      latch_q <= latch_d;
      ack_pend_q <= ack_pend_d;
      if (sc_wr) begin
        ctrl_q.mode <= wd[`EIRQ_MODE_BIT]; // RULE_16
        ctrl_q.mask <= wd[`EIRQ_MASK_BIT]; // RULE_15
      end
      if (bc_wr) begin
        bce_q <= wd[`EIRQ_BCE_BIT];
      end
      req_q <= latch_d & ~(sc_wr ? wd[`EIRQ_MASK_BIT] : ctrl_q.mask); // RULE_09
      pin_q <= sync2_q; // RULE_19
    end
  end

  assign irq_request = req_q;
  assign pin_level   = pin_q;

  // ************************************************
  // write handshake
  // ************************************************
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      wst_q     <= ext_irq_pkg::wr_idle;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `EIRQ_RESP_OKAY;
    end else if (clk_en) begin
      unique case (wst_q)
        ext_irq_pkg::wr_idle: begin
          if (aw_take) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr[`EIRQ_ADDR_W-1:0];
          end
          if (w_take) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
          end
          awready_q <= ~aw_now;
          wready_q  <= ~w_now;
          if (wr_fire) begin
            wst_q     <= ext_irq_pkg::wr_resp;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `EIRQ_RESP_OKAY : `EIRQ_RESP_SLVERR;
          end
        end
        ext_irq_pkg::wr_resp: begin
          if (s_axi_bready) begin
            bvalid_q  <= 1'b0;
            wst_q     <= ext_irq_pkg::wr_idle;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ************************************************
  // read channel
  // ************************************************
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire logic [`EIRQ_ADDR_W-1:0] ra = s_axi_araddr[`EIRQ_ADDR_W-1:0];
  wire logic ra_hi_ok = (s_axi_araddr[31:`EIRQ_ADDR_W] == '0);
  wire logic ar_take  = s_axi_arvalid & arready_q;
  // pending flag shows the latch, not the masked request; ack reads zero
  wire logic [31:0] sc_val = {27'h0, pin_q, latch_q, 1'b0, ctrl_q.mask, ctrl_q.mode}; // RULE_12 RULE_13 RULE_14
  wire logic [31:0] bc_val = {31'h0, bce_q};
  wire logic [31:0] vec_val = {`EIRQ_VECTOR_HI_LOC, `EIRQ_VECTOR_LO_LOC}; // RULE_11
  wire logic rd_sc  = ra_hi_ok & (ra == `EIRQ_STATUS_CONTROL_ADDR);
  wire logic rd_bc  = ra_hi_ok & (ra == `EIRQ_BREAK_CTRL_ADDR);
  wire logic rd_vec = ra_hi_ok & (ra == `EIRQ_VECTOR_ADDR);
  wire logic [31:0] rd_val = rd_sc ? sc_val : rd_bc ? bc_val : rd_vec ? vec_val : 32'h0;
  wire logic rd_ok  = rd_sc | rd_bc | rd_vec;

  always_ff @(posedge clk) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= `EIRQ_RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_ok ? `EIRQ_RESP_OKAY : `EIRQ_RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (~rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence fall_seen;
    clk_en & fall_edge;
  endsequence

  edge_sets_latch_a: assert property (fall_seen |=> latch_q) // RULE_01
    else $error("falling edge did not set latch");
  fetch_clears_a: assert property (
    clk_en & vector_fetch & ~fall_edge & ~(ctrl_q.mode & pin_low) |=> ~latch_q) // RULE_02
    else $error("vector fetch did not clear latch");
  sw_ack_clears_a: assert property (
    clk_en & sw_ack & ~fall_edge & ~ctrl_q.mode |=> ~latch_q) // RULE_03
    else $error("software acknowledge did not clear latch");
  edge_hold_a: assert property (
    clk_en & latch_q & ~ack_any & ~ack_pend_q |=> latch_q) // RULE_05
    else $error("latch dropped without acknowledge");
  ack_order_a: assert property (
    clk_en & latch_q & ack_pend_q & ctrl_q.mode & ~pin_low |=> ~latch_q | $past(fall_edge)) // RULE_07
    else $error("level mode latch kept after earlier acknowledge");
  level_hold_a: assert property (
    clk_en & latch_q & ctrl_q.mode & pin_low |=> latch_q) // RULE_06
    else $error("level mode latch cleared while pin low");
  mask_gate_a: assert property (
    clk_en & ctrl_q.mask & ~sc_wr |=> ~irq_request) // RULE_09
    else $error("masked request reached priority logic");
  flag_read_a: assert property (
    ar_take & rd_sc & clk_en |=> s_axi_rdata[`EIRQ_FLAG_BIT] == $past(latch_q)) // RULE_12
    else $error("pending flag mismatches latch");
  ack_reads_zero_a: assert property (
    clk_en & ar_take & rd_sc |=> ~s_axi_rdata[`EIRQ_ACK_BIT]) // RULE_14
    else $error("acknowledge bit read as one");
  break_protect_a: assert property (
    clk_en & break_state & ~bce_q & latch_q & ~vector_fetch & ~ack_pend_q |=> latch_q) // RULE_17
    else $error("latch cleared in protected break");

endmodule

// ===== inc/ext_irq_params.svh
// constants for the external interrupt latch block
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH
// register byte addresses
`define EIRQ_STATUS_CONTROL_ADDR 4'h0
`define EIRQ_BREAK_CTRL_ADDR     4'h4
`define EIRQ_VECTOR_ADDR         4'h8
`define EIRQ_ADDR_W              4
// status/control field positions
`define EIRQ_MODE_BIT            0
`define EIRQ_MASK_BIT            1
`define EIRQ_ACK_BIT             2
`define EIRQ_FLAG_BIT            3
`define EIRQ_PIN_BIT             4
// break control field position
`define EIRQ_BCE_BIT             0
// vector locations, read-only
`define EIRQ_VECTOR_HI_LOC       16'hfffa
`define EIRQ_VECTOR_LO_LOC       16'hfffb
// axi responses
`define EIRQ_RESP_OKAY           2'h0
`define EIRQ_RESP_SLVERR         2'h2
`endif

// ===== inc/ext_irq_pkg.sv
// types for the external interrupt latch block
package ext_irq_pkg;
  typedef struct packed {
    logic mode;
    logic mask;
  } ctrl_s;
  typedef enum logic [0:0] {
    wr_idle = 1'b0,
    wr_resp = 1'b1
  } wr_state_e;
endpackage
